//--- rtl/sps_top.sv
/*
 * Socket power and housekeeping block: APB registers, power switch
 * link, card reset, clock stop handshake and ZV address float.
 * Assumes one clock domain; all pins synchronous to clock.
 */
`timescale 1ns/100ps
`default_nettype none
module sps_top
    import sps_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,            // Host reset, async
    input  wire logic        ce,             // Clock enable
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  ccd_a_n,        // Socket A detect
    input  wire logic [1:0]  cvs_a,          // Socket A sense
    input  wire logic [1:0]  ccd_b_n,        // Socket B detect
    input  wire logic [1:0]  cvs_b,          // Socket B sense
    input  wire logic [1:0]  zv_det,         // ZV card flag, B:A
    input  wire logic        cclkrun_n_i,    // Clock run pin in
    output logic             cclkrun_n_o,    // Clock run pin out
    output logic             cclkrun_n_oe,   // Clock run pin drive
    output logic             card_clk_en,    // Card clock gate
    output logic             int_clk_en,     // Internal clock gate
    output logic [1:0]       card_rst_n,     // Card resets, B:A
    output logic             card_addr_hi_oe,// High address drive
    output logic             psw_clk,        // Switch serial clock
    output logic             psw_data,       // Switch serial data
    output logic             psw_latch       // Switch latch
);
    // No IDE, DMA, lock, multifunction or serial IRQ here
    // Everything samples on the rising edge of clock

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    sps_det_s        det_a, det_b;        // Decoded sockets
    logic [1:0]      det_pres;            // Present, B:A
    logic [1:0]      det_cb;              // CardBus, B:A
    sps_pwr_s        pwr_r, pwr_nxt;      // Power word register
    logic [CS_W-1:0] card_r, card_nxt;    // card_settings_reg
    logic [BS_W-1:0] brg_r, brg_nxt;      // bridge_settings_reg
    logic            power_switch_off_n_r, power_switch_off_n_nxt;    // Shutdown transfer owed
    logic            pend_r, pend_nxt;    // Power transfer owed
    logic [1:0]      pres_r, pres_nxt;    // Previous presence
    logic [1:0]      pcyc_r, pcyc_nxt;    // Power cycle running
    logic [1:0]      crst_nxt;            // Card reset next
    logic [31:0]     rd_nxt;              // Read data next
    logic            wr_en;               // Write access
    logic            rd_setup;            // Read setup cycle
    logic [1:0]      ins, rem;            // Insert, remove events
    logic            ser_start;           // Launch transfer
    logic            ser_busy, ser_done;
    logic [WORD_W-1:0] ser_word;          // Word to send
    sps_run_e        cr_r, cr_nxt;        // Clock run state
    logic            cclk_nxt;            // Card clock gate next

    // ----------------------------------------
    // Address decode helpers
    // ----------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADR_PRESENT) || (a == ADR_POWER) ||
                 (a == ADR_CARD) || (a == ADR_BRIDGE);
    endfunction

    // Read mux for one address
    function automatic logic [31:0] rd_mux(
        input logic [7:0] a, input sps_det_s da, input sps_det_s db,
        input sps_pwr_s p, input logic busy, input logic pend,
        input logic [CS_W-1:0] cs, input logic [BS_W-1:0] bs);
        logic [31:0] v;
        v = '0;
        unique case (a)
            ADR_PRESENT: begin  // Same layout as power word
                v[7:0] = {db.vcc, db.vpp, da.vpp, da.vcc};
                v[PR_PRES_LSB +: 2] = {db.present, da.present};
                v[PR_CB_LSB +: 2] = {db.cardbus, da.cardbus};
            end
            ADR_POWER: begin
                v[7:0] = p;
                v[PW_BUSY_BIT] = busy;
                v[PW_PEND_BIT] = pend;
            end
            ADR_CARD:   v[CS_W-1:0] = cs;
            ADR_BRIDGE: v[BS_W-1:0] = bs;
            default:    v = '0;  // Unmapped reads zero
        endcase
        rd_mux = v;
    endfunction

    // ----------------------------------------
    // Card detect decoders
    // ----------------------------------------
    sps_cdet u_det_a (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .ccd_n (ccd_a_n),
        .cvs   (cvs_a),
        .det   (det_a)
    );

    sps_cdet u_det_b (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .ccd_n (ccd_b_n),
        .cvs   (cvs_b),
        .det   (det_b)
    );

    assign det_pres = {det_b.present, det_a.present};
    assign det_cb = {det_b.cardbus, det_a.cardbus};

    // ----------------------------------------
    // Power switch serializer
    // ----------------------------------------
    sps_ser #(
        .W   (WORD_W),
        .DIV (SER_DIV)
    ) u_ser (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .start (ser_start),
        .word  (ser_word),
        .busy  (ser_busy),
        .done  (ser_done),
        .sclk  (psw_clk),
        .sdata (psw_data),
        .latch (psw_latch)
    );

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    // Read data is caught in setup, so access ends at once
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    // Presence edges against the previous sample
    assign ins = det_pres & ~pres_r;
    assign rem = pres_r & ~det_pres;

    // Shutdown word first, then the programmed word
    assign ser_start = (power_switch_off_n_r | pend_r) & ~ser_busy;
    assign ser_word = power_switch_off_n_r ? WORD_OFF : {1'b1, pwr_r};

    // ----------------------------------------
    // Register group next values
    // ----------------------------------------
    always_comb begin
        pwr_nxt = pwr_r;
        card_nxt = card_r;
        brg_nxt = brg_r;
        power_switch_off_n_nxt = power_switch_off_n_r;
        pend_nxt = pend_r;
        pres_nxt = det_pres;
        pcyc_nxt = pcyc_r;
        rd_nxt = prdata;
        // Launch clears the owed flag of the word it sends
        if (ser_start) begin
            if (power_switch_off_n_r) begin
                power_switch_off_n_nxt = 1'b0;
            end else begin
                pend_nxt = 1'b0;
            end
        end
        // Software writes
        if (wr_en) begin
            unique case (paddr)
                ADR_POWER: begin
                    pwr_nxt = pwdata[7:0];
                    pend_nxt = 1'b1;
                end
                ADR_CARD:   card_nxt = pwdata[CS_W-1:0];
                ADR_BRIDGE: brg_nxt = pwdata[BS_W-1:0];
                default: ;  // Unmapped ignored
            endcase
        end
        // Removal overrides software for that socket only
        if (rem[0]) begin
            pwr_nxt.vcc_a = VCC_0V;
            pwr_nxt.vpp_a = VPP_0V;
            pend_nxt = 1'b1;
        end
        if (rem[1]) begin
            pwr_nxt.vcc_b = VCC_0V;
            pwr_nxt.vpp_b = VPP_0V;
            pend_nxt = 1'b1;
        end
        // ZV insertion sets mode, beating a clear
        if (|(ins & zv_det)) begin
            card_nxt[CS_ZV_BIT] = 1'b1;
        end
        // Power cycle spans until next latch
        if (ser_done) begin
            pcyc_nxt = 2'b00;
        end
        pcyc_nxt = pcyc_nxt | ins | rem;
        // Software reset honoured for CardBus only
        crst_nxt = ~(pcyc_nxt | (brg_nxt & det_cb));
        if (rd_setup) begin
            rd_nxt = rd_mux(paddr, det_a, det_b, pwr_r, ser_busy,
                            pend_r, card_r, brg_r);
        end
    end

    // ----------------------------------------
    // Register group flops
    // ----------------------------------------
    // Host reset clears all but run bit, clock gate and address drive, and owes a shutdown word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwr_r <= POWER_RST;
            card_r <= CARD_RST;
            brg_r <= BRIDGE_RST;
            power_switch_off_n_r <= 1'b1;
            pend_r <= 1'b0;
            pres_r <= 2'b00;
            pcyc_r <= 2'b00;
            card_rst_n <= 2'b00;
            prdata <= '0;
            int_clk_en <= 1'b1;
            card_addr_hi_oe <= 1'b1;
        end else if (ce) begin
            pwr_r <= pwr_nxt;
            card_r <= card_nxt;
            brg_r <= brg_nxt;
            power_switch_off_n_r <= power_switch_off_n_nxt;
            pend_r <= pend_nxt;
            pres_r <= pres_nxt;
            pcyc_r <= pcyc_nxt;
            card_rst_n <= crst_nxt;
            prdata <= rd_nxt;
            int_clk_en <= card_nxt[CS_RUN_BIT];
            card_addr_hi_oe <= ~card_nxt[CS_ZV_BIT];
        end
    end

    // ----------------------------------------
    // Clock run handshake next state
    // ----------------------------------------
    // Line is owned low while running; a stop request parks it
    // high, floats it, then checks whether the card objects.
    always_comb begin
        cr_nxt = cr_r;
        unique case (cr_r)
            CR_RUN: begin
                if (card_r[CS_STOP_BIT]) begin
                    cr_nxt = CR_PARK;
                end
            end
            CR_PARK: cr_nxt = CR_FLOAT;
            CR_FLOAT: begin
                cr_nxt = cclkrun_n_i ? CR_STOP : CR_WAIT;
            end
            CR_STOP: begin
                if (!cclkrun_n_i) begin
                    cr_nxt = CR_WAIT;  // Card wants clock
                end else if (!card_r[CS_STOP_BIT]) begin
                    cr_nxt = CR_GAP;
                end
            end
            CR_WAIT: begin
                if (cclkrun_n_i) begin
                    cr_nxt = CR_GAP;  // Card released line
                end
            end
            CR_GAP: cr_nxt = CR_RUN;
        endcase
        // Suspend wins over the run handshake
        cclk_nxt = (cr_nxt != CR_STOP) & card_nxt[CS_RUN_BIT];
    end

    // ----------------------------------------
    // Clock run handshake flops
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cr_r <= CR_RUN;
            card_clk_en <= 1'b1;
        end else if (ce) begin
            cr_r <= cr_nxt;
            card_clk_en <= cclk_nxt;
        end
    end

    // Pin drive: low while running, high while parking
    assign cclkrun_n_o = (cr_r == CR_PARK);
    assign cclkrun_n_oe = (cr_r == CR_RUN) | (cr_r == CR_PARK);
endmodule
`default_nettype wire

//--- rtl/sps_pkg.sv
/*
 * Constants, carriers and state types of the socket power and
 * housekeeping block. Assumes one 200 MHz clock and an APB slave port.
 */
// Overview of operation
// - Decode sense pins into type and voltage
// - Power register write sends word to switch
// - Three switch outputs: clock, data, latch
// - Serial clock is bus clock over 16
// - Host reset powers sockets down unaided
// - Removal powers down only that socket
// - Shutdown bit low only after host reset
// - Supply and programming voltage field codes
// - Internal clock halts when run bit low
// - Card clock stops via run handshake or run bit low
// - Suspend overrides clock run control
// - Card reset during insertion/removal power cycle
// - Software card reset for CardBus only
// - ZV card insertion sets ZV enable
// - ZV mode floats high card address lines
// - No IDE, DMA, lock, multifunction, serial IRQ
// - Drive shared line high before releasing
// - Wait one clock before taking line
// - Asynchronous host reset clears all but run bit, clock gates, address drive and shutdown flag
// - All bus signals on rising clock edge
package sps_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADR_PRESENT = 8'h00;  // Socket presence, read only
    localparam logic [7:0] ADR_POWER   = 8'h04;  // Socket power word
    localparam logic [7:0] ADR_CARD    = 8'h08;  // card_settings_reg
    localparam logic [7:0] ADR_BRIDGE  = 8'h0C;  // bridge_settings_reg
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PR_PRES_LSB = 8;   // Present flags, A then B
    localparam int PR_CB_LSB   = 10;  // CardBus flags, A then B
    localparam int PW_BUSY_BIT = 8;   // Transfer in progress
    localparam int PW_PEND_BIT = 9;   // Transfer queued
    localparam int CS_RUN_BIT  = 0;   // Internal clock run
    localparam int CS_ZV_BIT   = 1;   // ZV mode enable
    localparam int CS_STOP_BIT = 2;   // Card clock stop request
    localparam int CS_W        = 3;
    localparam int BS_W        = 2;   // Card reset bits, A then B
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0]      POWER_RST  = 8'h00;
    localparam logic [CS_W-1:0] CARD_RST   = 3'h1;
    localparam logic [BS_W-1:0] BRIDGE_RST = 2'h0;
    // ----------------------------------------
    // Serial link
    // ----------------------------------------
    localparam int         SER_DIV  = 16;      // Bus clocks per serial clock
    localparam int         WORD_W   = 9;       // Shutdown bit plus D7:D0
    localparam logic [8:0] WORD_OFF = 9'h000;  // Shutdown word
    // ----------------------------------------
    // Voltage codes
    // ----------------------------------------
    localparam logic [1:0] VCC_0V_HI = 2'h3;
    localparam logic [1:0] VCC_5V    = 2'h2;
    localparam logic [1:0] VCC_3V3   = 2'h1;
    localparam logic [1:0] VCC_0V    = 2'h0;
    localparam logic [1:0] VPP_HIZ   = 2'h3;
    localparam logic [1:0] VPP_12V   = 2'h2;
    localparam logic [1:0] VPP_VCC   = 2'h1;
    localparam logic [1:0] VPP_0V    = 2'h0;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] vcc_b;  // D7:D6
        logic [1:0] vpp_b;  // D5:D4
        logic [1:0] vpp_a;  // D3:D2
        logic [1:0] vcc_a;  // D1:D0
    } sps_pwr_s;
    typedef struct packed {
        logic       present;
        logic       cardbus;
        logic [1:0] vcc;
        logic [1:0] vpp;
    } sps_det_s;
    typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_LATCH} sps_ser_e;
    typedef enum logic [2:0] {
        CR_RUN, CR_PARK, CR_FLOAT, CR_STOP, CR_WAIT, CR_GAP
    } sps_run_e;
endpackage

//--- rtl/sps_cdet.sv
/*
 * Card type and voltage decoder for one socket.
 * Assumes sense pins synchronous to clock; open pins read high.
 */
`timescale 1ns/100ps
`default_nettype none
module sps_cdet
    import sps_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [1:0] ccd_n,    // Card detect pins
    input  wire logic [1:0] cvs,      // Voltage sense pins
    output sps_det_s        det       // Registered result
);
    sps_det_s det_nxt;  // Decoded value

    // ----------------------------------------
    // Decode pins into type and supply
    // ----------------------------------------
    always_comb begin
        det_nxt = '0;
        det_nxt.vcc = VCC_0V;
        unique case (ccd_n)
            2'b00: begin  // 16-bit card
                det_nxt.present = 1'b1;
                unique case (cvs)
                    2'b11:   det_nxt.vcc = VCC_5V;
                    2'b01:   det_nxt.vcc = VCC_0V;  // Unsupported low volt
                    default: det_nxt.vcc = VCC_3V3;
                endcase
            end
            2'b01: begin  // CD2 tied to sense pin
                det_nxt.present = 1'b1;
                det_nxt.cardbus = 1'b1;
                det_nxt.vcc = (~cvs[0] | ~cvs[1]) ? VCC_3V3 : VCC_0V;
            end
            2'b10: begin  // CD1 tied to sense pin
                det_nxt.present = 1'b1;
                det_nxt.cardbus = 1'b1;
                det_nxt.vcc = cvs[1] ? VCC_3V3 : VCC_0V;
            end
            default: det_nxt.present = 1'b0;  // Empty socket
        endcase
        det_nxt.vpp = (det_nxt.vcc == VCC_0V) ? VPP_0V : VPP_VCC;
    end

    // ----------------------------------------
    // Result register
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            det <= '0;
        end else if (ce) begin
            det <= det_nxt;
        end
    end
endmodule
`default_nettype wire

//--- rtl/sps_ser.sv
/*
 * Three-wire serializer toward the power switch.
 * Assumes start is only raised while busy is low.
 */
`timescale 1ns/100ps
`default_nettype none
module sps_ser
    import sps_pkg::*;
#(
    parameter int W   = WORD_W,   // Word width
    parameter int DIV = SER_DIV   // Clock divide ratio
)(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         start,  // Load word and send
    input  wire logic [W-1:0] word,   // Word, MSB first
    output logic              busy,   // Transfer under way
    output logic              done,   // Latch finished pulse
    output logic              sclk,   // Serial clock
    output logic              sdata,  // Serial data
    output logic              latch   // Latch strobe
);
    localparam int DW = $clog2(DIV);
    localparam int BW = $clog2(W);
    sps_ser_e       st_r, st_nxt;     // Sequencer state
    logic [DW-1:0]  div_r, div_nxt;   // Divider count
    logic [BW-1:0]  bit_r, bit_nxt;   // Bits sent
    logic [W-1:0]   sh_r, sh_nxt;     // Shift register
    logic           sclk_nxt, sdata_nxt, latch_nxt, done_nxt;
    logic           wrap;             // End of serial period

    assign wrap = (div_r == DW'(DIV - 1));
    assign busy = (st_r != SER_IDLE);

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        div_nxt = div_r + 1'b1;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        done_nxt = 1'b0;
        unique case (st_r)
            SER_IDLE: begin
                div_nxt = '0;
                if (start) begin
                    sh_nxt = word;
                    bit_nxt = '0;
                    st_nxt = SER_SHIFT;
                end
            end
            SER_SHIFT: begin
                if (wrap) begin  // Data moves while clock low
                    if (bit_r == BW'(W - 1)) begin
                        st_nxt = SER_LATCH;
                    end else begin
                        bit_nxt = bit_r + 1'b1;
                        sh_nxt = {sh_r[W-2:0], 1'b0};
                    end
                end
            end
            SER_LATCH: begin
                if (wrap) begin
                    st_nxt = SER_IDLE;
                    done_nxt = 1'b1;
                end
            end
        endcase
        sclk_nxt = (st_nxt == SER_SHIFT) && div_nxt[DW-1];
        sdata_nxt = (st_nxt == SER_SHIFT) && sh_nxt[W-1];
        latch_nxt = (st_nxt == SER_LATCH);
    end

    // ----------------------------------------
    // Sequencer registers
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= SER_IDLE;
            div_r <= '0;
            bit_r <= '0;
            sh_r <= '0;
            sclk <= 1'b0;
            sdata <= 1'b0;
            latch <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            sclk <= sclk_nxt;
            sdata <= sdata_nxt;
            latch <= latch_nxt;
            done <= done_nxt;
        end
    end
endmodule
`default_nettype wire

//--- tb/sps_props.sv
/* Checker for sps_top: serial link timing, reset, clock run line.
   Assumes one clock domain and bind onto every sps_top. */
`timescale 1ns/100ps
`default_nettype none
module sps_props (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       psw_clk, psw_data, psw_latch,
    input wire logic       cclkrun_n_i, cclkrun_n_o, cclkrun_n_oe,
    input wire logic       card_clk_en, int_clk_en,
    input wire logic [1:0] card_rst_n
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sclk_high_a: assert property ($rose(psw_clk) |-> psw_clk[*8] ##1 !psw_clk)
        else $error("serial clock high phase wrong");
    sclk_low_a: assert property ($fell(psw_clk) |-> !psw_clk[*8])
        else $error("serial clock low phase short");
    data_hold_a: assert property (psw_clk |-> $stable(psw_data))
        else $error("data moved while serial clock high");
    latch_len_a: assert property ($rose(psw_latch) |-> psw_latch[*8] ##1 psw_latch[*8] ##1 !psw_latch)
        else $error("latch pulse length wrong");
    latch_clk_a: assert property (psw_latch |-> !psw_clk && (!$rose(psw_latch) || $past(psw_clk)))
        else $error("latch not right after last serial bit");
    reset_off_a: assert property (disable iff (1'b0) rst |-> !psw_clk && !psw_latch && card_rst_n == 2'h0)
        else $error("outputs not cleared in reset");
    park_high_a: assert property ($fell(cclkrun_n_oe) |-> $past(cclkrun_n_o))
        else $error("clock run released without high");
    take_gap_a: assert property ($rose(cclkrun_n_oe) |-> !$past(cclkrun_n_oe, 2))
        else $error("clock run taken too soon");
    clk_stop_a: assert property ($fell(card_clk_en) |-> !int_clk_en || $past(cclkrun_n_i))
        else $error("card clock stopped while held");
endmodule
bind sps_top sps_props chk_u (.clock, .rst, .psw_clk, .psw_data, .psw_latch, .cclkrun_n_i, .cclkrun_n_o,
    .cclkrun_n_oe, .card_clk_en, .int_clk_en, .card_rst_n);
`default_nettype wire

//--- tb/sps_psw_model.sv
/* Power switch model: shifts on serial clock rise, takes word on latch.
   Assumes the link is sampled with the bus clock. */
`timescale 1ns/100ps
`default_nettype none
module sps_psw_model (
    input wire logic       clock,
    input wire logic       psw_clk, psw_data, psw_latch,
    output logic     [8:0] word,
    output int             n_words
);
    logic [8:0] sh_r;          // Bits gathered so far
    logic       clk_d, lat_d;  // Previous line levels
    initial n_words = 0;
    // Shift MSB first, take whole word on latch rise
    always @(posedge clock) begin
        clk_d <= psw_clk;
        lat_d <= psw_latch;
        if (psw_clk && !clk_d) sh_r <= {sh_r[7:0], psw_data};
        if (psw_latch && !lat_d) begin
            word <= sh_r;
            n_words <= n_words + 1;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/* Self-checking bench for sps_top with switch model and card pins.
   Assumes sps_pkg is compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sps_pkg::*;
    // ----------------------------------------
    // Stimulus and observation
    // ----------------------------------------
    logic        clock = 0, rst = 0, psel = 0, penable = 0, pwrite = 0, card_drv = 0, err;
    logic [7:0]  paddr = 0, pw;
    logic [31:0] pwdata = 0, prdata, rd, lf = 32'hB24E;
    logic        pready, pslverr, cclkrun_n_o, cclkrun_n_oe, card_clk_en, int_clk_en;
    logic        card_addr_hi_oe, psw_clk, psw_data, psw_latch;
    logic [1:0]  ccd_a_n = 2'h3, cvs_a = 2'h3, ccd_b_n = 2'h3, cvs_b = 2'h3, zv_det = 2'h0, card_rst_n;
    logic [8:0]  word;
    int          n_words, n_mismatch = 0, check_count = 0;
    wire         cclkrun_w = cclkrun_n_oe ? cclkrun_n_o : !card_drv;  // Pull-up when nobody drives
    always #2.5 clock = ~clock;
    sps_top dut_u (.clock, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ccd_a_n, .cvs_a, .ccd_b_n, .cvs_b, .zv_det, .cclkrun_n_i(cclkrun_w), .cclkrun_n_o,
        .cclkrun_n_oe, .card_clk_en, .int_clk_en, .card_rst_n, .card_addr_hi_oe, .psw_clk, .psw_data, .psw_latch);
    sps_psw_model psw_u (.clock, .psw_clk, .psw_data, .psw_latch, .word, .n_words);
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // APB transfer: setup, then access until pready
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clock);
        if (i == 20) begin n_mismatch++; test_done(); end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Wait for the next latched word and compare it
    task automatic expect_word(logic [8:0] exp);
        int i, n;
        n = n_words;
        for (i = 0; i < 400 && n_words == n; i++) @(posedge clock);
        if (i == 400) begin n_mismatch++; test_done(); end
        chk(word, exp);
    endtask
    task automatic wait_clk_en(logic v);
        int i;
        for (i = 0; i < 40 && card_clk_en !== v; i++) @(posedge clock);
        chk(card_clk_en, v);
        if (i == 40) test_done();
    endtask
    initial begin
        rst <= 1;
        repeat (16) @(posedge clock);
        rst <= 0;
        expect_word(9'h000);
        apb(0, ADR_CARD, 0);
        chk(rd, 32'h1);
        apb(0, 8'h10, 0);
        chk(rd, 0);
        chk(err, 1);
        repeat (4) begin
            lf = lfsr(lf);
            pw = lf[7:0];
            apb(1, ADR_POWER, lf);
            expect_word({1'b1, pw});
        end
        zv_det <= 2'h1;
        ccd_a_n <= 2'h0;
        repeat (6) @(posedge clock);
        chk(card_rst_n[0], 0);
        apb(0, ADR_PRESENT, 0);
        pw = {4'h9, rd[3:0]};
        apb(1, ADR_POWER, pw);
        expect_word({1'b1, pw});
        repeat (20) @(posedge clock);
        chk(card_rst_n[0], 1);
        apb(1, ADR_BRIDGE, 1);
        repeat (3) @(posedge clock);
        chk(card_rst_n[0], 1);
        apb(0, ADR_CARD, 0);
        chk(rd[CS_ZV_BIT], 1);
        chk(card_addr_hi_oe, 0);
        apb(1, ADR_CARD, 0);
        repeat (2) @(posedge clock);
        chk(int_clk_en, 0);
        card_drv <= 1;
        apb(1, ADR_CARD, 5);
        repeat (10) @(posedge clock);
        chk(card_clk_en, 1);
        card_drv <= 0;
        wait_clk_en(0);
        apb(1, ADR_CARD, 1);
        wait_clk_en(1);
        ccd_a_n <= 2'h3;
        ccd_b_n <= 2'h2;
        expect_word({1'b1, pw[7:4], 4'h0});
        apb(0, ADR_PRESENT, 0);
        chk(rd[11:4], 8'hA5);
        repeat (20) @(posedge clock);
        chk(card_rst_n[1], 1);
        apb(1, ADR_BRIDGE, 2);
        repeat (2) @(posedge clock);
        chk(card_rst_n[1], 0);
        apb(1, ADR_POWER, 8'hFF);
        repeat (40) @(posedge clock);
        rst <= 1;
        repeat (3) @(posedge clock);
        rst <= 0;
        expect_word(9'h000);
        apb(0, ADR_POWER, 0);
        chk(rd[7:0], 0);
        test_done();
    end
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
